// ---- design/ctr_pkg.sv ----
// Constants, field layouts and types for the tag refresh pointer and index logic.
// Assumes one clock domain and register transfers addressed by register number.
// Behaviour
// - Refresh pointer holds backup and primary rows.
// - Pointer write refreshes both stores together.
// - Auto refresh increments each pointer after refresh.
// - 32 primary, 256 backup refreshes cover all.
// - Manual mode changes pointers only by write.
// - Manual mode refreshes only explicitly accessed rows.
// - Manual mode indexes tag stores from pointer.
// - Pointer unused bits read zero, written zero.
// - Primary refresh covers that row in both banks.
// - Backup access uses index rows 16:9, column 8:6.
// - Primary access uses column 10:9, row 8:4.
// - Index read whole, write changes bits 16:4.
// - Index bits outside views read zero.
package ctr_pkg;
    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [7:0] CTR_XPR_BTAG = 8'h71;
    localparam logic [7:0] CTR_XPR_PBANK1 = 8'h72;
    localparam logic [7:0] CTR_XPR_PBANK2 = 8'h73;
    localparam logic [7:0] CTR_XPR_RFR = 8'h74;
    localparam logic [7:0] CTR_XPR_IDX = 8'h75;
    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int CTR_BTAG_ROW_W = 8;
    localparam int CTR_PTAG_ROW_W = 5;
    localparam int CTR_BTAG_COL_W = 3;
    localparam int CTR_PTAG_COL_W = 2;
    localparam int CTR_IDX_W = 13;
    localparam int CTR_RFR_BTAG_MSB = 16;
    localparam int CTR_RFR_BTAG_LSB = 9;
    localparam int CTR_RFR_PTAG_MSB = 8;
    localparam int CTR_RFR_PTAG_LSB = 4;
    localparam int CTR_IDX_MSB = 16;
    localparam int CTR_IDX_LSB = 4;
    localparam int CTR_IDX_BROW_MSB = 16;
    localparam int CTR_IDX_BROW_LSB = 9;
    localparam int CTR_IDX_BCOL_MSB = 8;
    localparam int CTR_IDX_BCOL_LSB = 6;
    localparam int CTR_IDX_PCOL_MSB = 10;
    localparam int CTR_IDX_PCOL_LSB = 9;
    localparam int CTR_IDX_PROW_MSB = 8;
    localparam int CTR_IDX_PROW_LSB = 4;
    // ------------------------------------------------------------
    // Values after reset and counts
    // ------------------------------------------------------------
    localparam logic [CTR_BTAG_ROW_W-1:0] CTR_BTAG_PTR_RST = 8'h00;
    localparam logic [CTR_PTAG_ROW_W-1:0] CTR_PTAG_PTR_RST = 5'h00;
    localparam logic [CTR_IDX_W-1:0] CTR_IDX_RST = 13'h0000;
    localparam logic [CTR_BTAG_ROW_W-1:0] CTR_BTAG_ROW_MAX = 8'hFF;
    localparam logic [CTR_PTAG_ROW_W-1:0] CTR_PTAG_ROW_MAX = 5'h1F;
    localparam logic [1:0] CTR_PBANK_BOTH = 2'h3;
    localparam logic [1:0] CTR_PBANK_NONE = 2'h0;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTR_SEL_BTAG,
        CTR_SEL_PBANK1,
        CTR_SEL_PBANK2,
        CTR_SEL_NONE
    } ctr_tag_sel_type;
endpackage : ctr_pkg

// ---- design/ctr_core_if.sv ----
// Carrier between the top and its pointer and index leaves.
// Assumes all three modules share mclk_in and rst_in.
`timescale 1ns/1ps
interface ctr_core_if;
    import ctr_pkg::*;
    logic ptr_load;
    logic [CTR_BTAG_ROW_W-1:0] ptr_load_btag;
    logic [CTR_PTAG_ROW_W-1:0] ptr_load_ptag;
    logic ptr_inc;
    logic [CTR_BTAG_ROW_W-1:0] ptr_btag;
    logic [CTR_PTAG_ROW_W-1:0] ptr_ptag;
    logic idx_load;
    logic [CTR_IDX_W-1:0] idx_wdata;
    logic [CTR_IDX_W-1:0] idx_value;
    modport ptr_mp (
        input ptr_load, ptr_load_btag, ptr_load_ptag, ptr_inc,
        output ptr_btag, ptr_ptag
    );
    modport idx_mp (
        input idx_load, idx_wdata,
        output idx_value
    );
endinterface : ctr_core_if

// ---- design/ctr_refresh_ptr.sv ----
// Refresh row pointers for the backup store and the primary copy.
// Assumes load and increment come from the top, never both at once.
`timescale 1ns/1ps
module ctr_refresh_ptr (
    input wire logic mclk_in,
    input wire logic rst_in,
    ctr_core_if.ptr_mp ptr_port
);
    import ctr_pkg::*;
    logic [CTR_BTAG_ROW_W-1:0] btag_ptr_reg, btag_ptr_next;
    logic [CTR_PTAG_ROW_W-1:0] ptag_ptr_reg, ptag_ptr_next;
    // ------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------
    // Natural width overflow gives the wrap, so no compare is needed
    always_comb begin
        btag_ptr_next = btag_ptr_reg;
        ptag_ptr_next = ptag_ptr_reg;
        if (ptr_port.ptr_load) begin
            btag_ptr_next = ptr_port.ptr_load_btag;
            ptag_ptr_next = ptr_port.ptr_load_ptag;
        end else if (ptr_port.ptr_inc) begin
            btag_ptr_next = btag_ptr_reg + 8'h01;
            ptag_ptr_next = ptag_ptr_reg + 5'h01;
        end
    end
    // Registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            btag_ptr_reg <= CTR_BTAG_PTR_RST;
            ptag_ptr_reg <= CTR_PTAG_PTR_RST;
        end else begin
            btag_ptr_reg <= btag_ptr_next;
            ptag_ptr_reg <= ptag_ptr_next;
        end
    end
    assign ptr_port.ptr_btag = btag_ptr_reg;
    assign ptr_port.ptr_ptag = ptag_ptr_reg;
endmodule : ctr_refresh_ptr

// ---- design/ctr_index_reg.sv ----
// Tag access index register, only bits 16:4 are stored.
// Assumes the top masks the write data down to those bits.
`timescale 1ns/1ps
module ctr_index_reg (
    input wire logic mclk_in,
    input wire logic rst_in,
    ctr_core_if.idx_mp idx_port
);
    import ctr_pkg::*;
    logic [CTR_IDX_W-1:0] idx_reg, idx_next;
    // ------------------------------------------------------------
    // Index update
    // ------------------------------------------------------------
    // Unstored bits cannot be written at all, which keeps them zero
    always_comb begin
        idx_next = idx_reg;
        if (idx_port.idx_load) begin
            idx_next = idx_port.idx_wdata;
        end
    end
    // Registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            idx_reg <= CTR_IDX_RST;
        end else begin
            idx_reg <= idx_next;
        end
    end
    assign idx_port.idx_value = idx_reg;
endmodule : ctr_index_reg

// ---- design/ctr_top.sv ----
// Top of the tag refresh pointer and index logic.
// Assumes register transfers arrive as one-cycle strobes on mclk_in, and
// that the cache control refresh enable bit is mirrored on auto_refresh_en_in.
`timescale 1ns/1ps
module ctr_top (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic xpr_valid_in,
    input wire logic xpr_write_in,
    input wire logic [7:0] xpr_addr_in,
    input wire logic [31:0] xpr_wdata_in,
    input wire logic auto_refresh_en_in,
    input wire logic refresh_tick_in,
    input wire logic normal_access_in,
    input wire logic [ctr_pkg::CTR_BTAG_ROW_W-1:0] normal_btag_row_in,
    input wire logic [ctr_pkg::CTR_PTAG_ROW_W-1:0] normal_ptag_row_in,
    output logic xpr_ack_out,
    output logic [31:0] xpr_rdata_out,
    output logic refresh_btag_out,
    output logic [1:0] refresh_ptag_banks_out,
    output logic [ctr_pkg::CTR_BTAG_ROW_W-1:0] refresh_btag_row_out,
    output logic [ctr_pkg::CTR_PTAG_ROW_W-1:0] refresh_ptag_row_out,
    output logic tag_access_out,
    output logic tag_write_out,
    output ctr_pkg::ctr_tag_sel_type tag_sel_out,
    output logic [ctr_pkg::CTR_BTAG_ROW_W-1:0] tag_btag_row_out,
    output logic [ctr_pkg::CTR_BTAG_COL_W-1:0] tag_btag_col_out,
    output logic [ctr_pkg::CTR_PTAG_ROW_W-1:0] tag_ptag_row_out,
    output logic [ctr_pkg::CTR_PTAG_COL_W-1:0] tag_ptag_col_out
);
    import ctr_pkg::*;

    // ------------------------------------------------------------
    // Leaves
    // ------------------------------------------------------------
    ctr_core_if core_if ();

    ctr_refresh_ptr u_ptr (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ptr_port(core_if.ptr_mp)
    );

    ctr_index_reg u_idx (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .idx_port(core_if.idx_mp)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic req_rd, req_wr;
    logic hit_rfr, hit_idx, hit_btag, hit_p1, hit_p2, hit_tag;
    logic [31:0] rfr_word, idx_word;

    // Register number decode and read views of both registers
    always_comb begin
        req_rd = xpr_valid_in && !xpr_write_in;
        req_wr = xpr_valid_in && xpr_write_in;
        hit_rfr = xpr_addr_in == CTR_XPR_RFR;
        hit_idx = xpr_addr_in == CTR_XPR_IDX;
        hit_btag = xpr_addr_in == CTR_XPR_BTAG;
        hit_p1 = xpr_addr_in == CTR_XPR_PBANK1;
        hit_p2 = xpr_addr_in == CTR_XPR_PBANK2;
        hit_tag = hit_btag || hit_p1 || hit_p2;
        rfr_word = {15'h0000, core_if.ptr_btag, core_if.ptr_ptag, 4'h0};
        idx_word = {15'h0000, core_if.idx_value, 4'h0};
    end

    // Leaf controls; a pointer write overrides a refresh tick in that cycle.
    // Pointer access with auto refresh on is left to software to avoid.
    assign core_if.ptr_load = req_wr && hit_rfr;
    assign core_if.ptr_load_btag = xpr_wdata_in[CTR_RFR_BTAG_MSB:CTR_RFR_BTAG_LSB];
    assign core_if.ptr_load_ptag = xpr_wdata_in[CTR_RFR_PTAG_MSB:CTR_RFR_PTAG_LSB];
    assign core_if.ptr_inc = auto_refresh_en_in && refresh_tick_in && !core_if.ptr_load;
    assign core_if.idx_load = req_wr && hit_idx;
    assign core_if.idx_wdata = xpr_wdata_in[CTR_IDX_MSB:CTR_IDX_LSB];

    // ------------------------------------------------------------
    // Output state
    // ------------------------------------------------------------
    logic xpr_ack_reg, xpr_ack_next;
    logic [31:0] xpr_rdata_reg, xpr_rdata_next;
    logic rf_btag_reg, rf_btag_next;
    logic [1:0] rf_pbanks_reg, rf_pbanks_next;
    logic [CTR_BTAG_ROW_W-1:0] rf_brow_reg, rf_brow_next;
    logic [CTR_PTAG_ROW_W-1:0] rf_prow_reg, rf_prow_next;
    logic ta_reg, ta_next;
    logic ta_wr_reg, ta_wr_next;
    ctr_tag_sel_type ta_sel_reg, ta_sel_next;
    logic [CTR_BTAG_ROW_W-1:0] ta_brow_reg, ta_brow_next;
    logic [CTR_BTAG_COL_W-1:0] ta_bcol_reg, ta_bcol_next;
    logic [CTR_PTAG_ROW_W-1:0] ta_prow_reg, ta_prow_next;
    logic [CTR_PTAG_COL_W-1:0] ta_pcol_reg, ta_pcol_next;

    // Answer, refresh strobes and tag access indices
    always_comb begin
        xpr_ack_next = xpr_valid_in;
        xpr_rdata_next = 32'h0000_0000;
        if (req_rd && hit_rfr) begin
            xpr_rdata_next = rfr_word;
        end else if (req_rd && hit_idx) begin
            xpr_rdata_next = idx_word;
        end
        // Columns always come from the index; rows switch to the pointer when auto is off
        ta_next = xpr_valid_in && hit_tag;
        ta_wr_next = xpr_valid_in && hit_tag && xpr_write_in;
        ta_sel_next = CTR_SEL_NONE;
        if (hit_btag) begin
            ta_sel_next = CTR_SEL_BTAG;
        end else if (hit_p1) begin
            ta_sel_next = CTR_SEL_PBANK1;
        end else if (hit_p2) begin
            ta_sel_next = CTR_SEL_PBANK2;
        end
        ta_bcol_next = idx_word[CTR_IDX_BCOL_MSB:CTR_IDX_BCOL_LSB];
        ta_pcol_next = idx_word[CTR_IDX_PCOL_MSB:CTR_IDX_PCOL_LSB];
        if (auto_refresh_en_in) begin
            ta_brow_next = idx_word[CTR_IDX_BROW_MSB:CTR_IDX_BROW_LSB];
            ta_prow_next = idx_word[CTR_IDX_PROW_MSB:CTR_IDX_PROW_LSB];
        end else begin
            ta_brow_next = core_if.ptr_btag;
            ta_prow_next = core_if.ptr_ptag;
        end
        // Refresh sources in priority order; a primary refresh always hits both banks
        rf_btag_next = 1'b0;
        rf_pbanks_next = CTR_PBANK_NONE;
        rf_brow_next = rf_brow_reg;
        rf_prow_next = rf_prow_reg;
        if (core_if.ptr_load) begin
            rf_btag_next = 1'b1;
            rf_pbanks_next = CTR_PBANK_BOTH;
            rf_brow_next = core_if.ptr_load_btag;
            rf_prow_next = core_if.ptr_load_ptag;
        end else if (auto_refresh_en_in && refresh_tick_in) begin
            rf_btag_next = 1'b1;
            rf_pbanks_next = CTR_PBANK_BOTH;
            rf_brow_next = core_if.ptr_btag;
            rf_prow_next = core_if.ptr_ptag;
        end else if (!auto_refresh_en_in && xpr_valid_in && hit_tag) begin
            rf_btag_next = hit_btag;
            rf_pbanks_next = hit_btag ? CTR_PBANK_NONE : CTR_PBANK_BOTH;
            rf_brow_next = ta_brow_next;
            rf_prow_next = ta_prow_next;
        end else if (!auto_refresh_en_in && normal_access_in) begin
            rf_btag_next = 1'b1;
            rf_pbanks_next = CTR_PBANK_BOTH;
            rf_brow_next = normal_btag_row_in;
            rf_prow_next = normal_ptag_row_in;
        end
    end

    // Registers; every output comes straight from here
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            xpr_ack_reg <= 1'b0;
            xpr_rdata_reg <= 32'h0000_0000;
            rf_btag_reg <= 1'b0;
            rf_pbanks_reg <= CTR_PBANK_NONE;
            rf_brow_reg <= CTR_BTAG_PTR_RST;
            rf_prow_reg <= CTR_PTAG_PTR_RST;
            ta_reg <= 1'b0;
            ta_wr_reg <= 1'b0;
            ta_sel_reg <= CTR_SEL_NONE;
            ta_brow_reg <= CTR_BTAG_PTR_RST;
            ta_bcol_reg <= 3'h0;
            ta_prow_reg <= CTR_PTAG_PTR_RST;
            ta_pcol_reg <= 2'h0;
        end else begin
            xpr_ack_reg <= xpr_ack_next;
            xpr_rdata_reg <= xpr_rdata_next;
            rf_btag_reg <= rf_btag_next;
            rf_pbanks_reg <= rf_pbanks_next;
            rf_brow_reg <= rf_brow_next;
            rf_prow_reg <= rf_prow_next;
            ta_reg <= ta_next;
            ta_wr_reg <= ta_wr_next;
            ta_sel_reg <= ta_sel_next;
            ta_brow_reg <= ta_brow_next;
            ta_bcol_reg <= ta_bcol_next;
            ta_prow_reg <= ta_prow_next;
            ta_pcol_reg <= ta_pcol_next;
        end
    end

    assign xpr_ack_out = xpr_ack_reg;
    assign xpr_rdata_out = xpr_rdata_reg;
    assign refresh_btag_out = rf_btag_reg;
    assign refresh_ptag_banks_out = rf_pbanks_reg;
    assign refresh_btag_row_out = rf_brow_reg;
    assign refresh_ptag_row_out = rf_prow_reg;
    assign tag_access_out = ta_reg;
    assign tag_write_out = ta_wr_reg;
    assign tag_sel_out = ta_sel_reg;
    assign tag_btag_row_out = ta_brow_reg;
    assign tag_btag_col_out = ta_bcol_reg;
    assign tag_ptag_row_out = ta_prow_reg;
    assign tag_ptag_col_out = ta_pcol_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence s_ptr_write;
        xpr_valid_in && xpr_write_in && xpr_addr_in == CTR_XPR_RFR;
    endsequence

    sequence s_auto_tick;
        auto_refresh_en_in && refresh_tick_in && !(xpr_valid_in && xpr_write_in && xpr_addr_in == CTR_XPR_RFR);
    endsequence

    sequence s_manual_quiet;
        !auto_refresh_en_in && !normal_access_in && !(xpr_valid_in && hit_tag)
            && !(xpr_valid_in && xpr_write_in && xpr_addr_in == CTR_XPR_RFR);
    endsequence

    property p_ptr_write_refresh;
        s_ptr_write |=> refresh_btag_out && refresh_ptag_banks_out == 2'h3
            && refresh_btag_row_out == $past(xpr_wdata_in[16:9])
            && refresh_ptag_row_out == $past(xpr_wdata_in[8:4]);
    endproperty
    a_ptr_write_refresh: assert property (p_ptr_write_refresh) else $error("pointer write did not refresh both");

    // The stored pointer, not only the refresh strobe, must follow the written fields
    property p_ptr_write_land;
        s_ptr_write |=> core_if.ptr_btag == $past(xpr_wdata_in[16:9])
            && core_if.ptr_ptag == $past(xpr_wdata_in[8:4]);
    endproperty
    a_ptr_write_land: assert property (p_ptr_write_land) else $error("pointer write did not land");

    property p_auto_inc;
        s_auto_tick |=> core_if.ptr_ptag == 5'($past(core_if.ptr_ptag) + 5'h01)
            && core_if.ptr_btag == 8'($past(core_if.ptr_btag) + 8'h01);
    endproperty
    a_auto_inc: assert property (p_auto_inc) else $error("auto refresh did not advance pointers");

    property p_ptag_wrap;
        s_auto_tick ##0 (core_if.ptr_ptag == 5'h1F) |=> core_if.ptr_ptag == 5'h00;
    endproperty
    a_ptag_wrap: assert property (p_ptag_wrap) else $error("primary pointer did not wrap");

    property p_btag_wrap;
        s_auto_tick ##0 (core_if.ptr_btag == 8'hFF) |=> core_if.ptr_btag == 8'h00;
    endproperty
    a_btag_wrap: assert property (p_btag_wrap) else $error("backup pointer did not wrap");

    property p_manual_hold;
        !auto_refresh_en_in && !(xpr_valid_in && xpr_write_in && xpr_addr_in == CTR_XPR_RFR)
            |=> $stable(core_if.ptr_btag) && $stable(core_if.ptr_ptag);
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("pointer moved without a write");

    property p_manual_no_refresh;
        s_manual_quiet |=> !refresh_btag_out && refresh_ptag_banks_out == 2'h0;
    endproperty
    a_manual_no_refresh: assert property (p_manual_no_refresh) else $error("refresh without access");

    property p_both_banks;
        refresh_ptag_banks_out != 2'h1 && refresh_ptag_banks_out != 2'h2;
    endproperty
    a_both_banks: assert property (p_both_banks) else $error("primary refresh hit one bank");

    property p_manual_index;
        !auto_refresh_en_in && xpr_valid_in && hit_tag
            |=> tag_access_out && tag_btag_row_out == $past(core_if.ptr_btag)
            && tag_ptag_row_out == $past(core_if.ptr_ptag);
    endproperty
    a_manual_index: assert property (p_manual_index) else $error("manual access not indexed by pointer");

    property p_btag_index;
        auto_refresh_en_in && xpr_valid_in && hit_btag
            |=> tag_sel_out == CTR_SEL_BTAG && tag_btag_row_out == $past(core_if.idx_value[12:5])
            && tag_btag_col_out == $past(core_if.idx_value[4:2]);
    endproperty
    a_btag_index: assert property (p_btag_index) else $error("backup index fields wrong");

    property p_ptag_index;
        auto_refresh_en_in && xpr_valid_in && (hit_p1 || hit_p2)
            |=> tag_ptag_col_out == $past(core_if.idx_value[6:5])
            && tag_ptag_row_out == $past(core_if.idx_value[4:0]);
    endproperty
    a_ptag_index: assert property (p_ptag_index) else $error("primary index fields wrong");

    property p_rfr_read;
        xpr_valid_in && !xpr_write_in && hit_rfr
            |=> xpr_ack_out && xpr_rdata_out[31:17] == 15'h0000 && xpr_rdata_out[3:0] == 4'h0
            && xpr_rdata_out[16:9] == $past(core_if.ptr_btag) && xpr_rdata_out[8:4] == $past(core_if.ptr_ptag);
    endproperty
    a_rfr_read: assert property (p_rfr_read) else $error("pointer read value wrong");

    property p_idx_write_read;
        xpr_valid_in && xpr_write_in && hit_idx ##1 xpr_valid_in && !xpr_write_in && hit_idx
            |=> xpr_rdata_out == {15'h0000, $past(xpr_wdata_in[16:4], 2), 4'h0};
    endproperty
    a_idx_write_read: assert property (p_idx_write_read) else $error("index write then read mismatch");

    // Only bits 16:4 of a write reach the stored index
    property p_idx_write_store;
        xpr_valid_in && xpr_write_in && hit_idx |=> core_if.idx_value == $past(xpr_wdata_in[16:4]);
    endproperty
    a_idx_write_store: assert property (p_idx_write_store) else $error("index write not stored");

    // Bits outside both index views never show up in a read
    property p_idx_read_zero;
        xpr_valid_in && !xpr_write_in && hit_idx
            |=> xpr_ack_out && xpr_rdata_out[31:17] == 15'h0000 && xpr_rdata_out[3:0] == 4'h0;
    endproperty
    a_idx_read_zero: assert property (p_idx_read_zero) else $error("index unused bits not zero");

endmodule : ctr_top

// ---- tb/ctr_cpu_model.sv ----
// CPU side model: issues one register transfer at a time and collects the answer.
// Assumes a one-cycle strobe and an acknowledge exactly one cycle later.
`timescale 1ns/1ps
module ctr_cpu_model (
    input wire logic mclk_in,
    input wire logic auto_refresh_en_in,
    input wire logic xpr_ack_in,
    input wire logic [31:0] xpr_rdata_in,
    output logic xpr_valid_out,
    output logic xpr_write_out,
    output logic [7:0] xpr_addr_out,
    output logic [31:0] xpr_wdata_out
);
    import ctr_pkg::*;
    initial begin
        xpr_valid_out = 1'h0;
        xpr_write_out = 1'h0;
        xpr_addr_out = 8'h00;
        xpr_wdata_out = 32'h0;
    end
    // One transfer; data lines show the inverse once released so stale data is never reused.
    // The refresh mode is judged after the edge, so a change made in the caller's step is seen.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic ok,
                        output logic [31:0] rd);
        logic [31:0] dm;
        dm = (a == CTR_XPR_RFR) ? (d & 32'h0001FFF0) : d;
        ok = 1'h0;
        rd = 32'h0;
        @(posedge mclk_in);
        if (a == CTR_XPR_RFR && auto_refresh_en_in) begin
            return;
        end
        xpr_valid_out <= 1'h1;
        xpr_write_out <= wr;
        xpr_addr_out <= a;
        xpr_wdata_out <= dm;
        @(posedge mclk_in);
        xpr_valid_out <= 1'h0;
        xpr_wdata_out <= ~dm;
        #1;
        ok = xpr_ack_in;
        rd = xpr_rdata_in;
    endtask : xfer
endmodule : ctr_cpu_model

// ---- tb/testbench.sv ----
// Self-checking bench for the tag refresh pointer and index logic.
// Assumes the CPU model in ctr_cpu_model and the design package.
`timescale 1ns/1ps
module testbench;
    import ctr_pkg::*;
    logic mclk_in = 1'h0, rst_in = 1'h1, auto_en = 1'h0, tick = 1'h0, norm = 1'h0, ok;
    logic [7:0] nb_row = 8'h00, addr, tbr, rf_brow, eb;
    logic [4:0] np_row = 5'h00, tpr, rf_prow, ep;
    logic [31:0] wdata, rdata, rd;
    logic valid, wr, ack, rf_b, tacc, twr;
    logic [1:0] rf_p, tpc;
    logic [2:0] tbc;
    ctr_tag_sel_type tsel;
    int n_errors = 0, total_checks = 0, cycles = 0;
    ctr_cpu_model CPU (.mclk_in(mclk_in), .auto_refresh_en_in(auto_en), .xpr_ack_in(ack),
        .xpr_rdata_in(rdata), .xpr_valid_out(valid), .xpr_write_out(wr), .xpr_addr_out(addr),
        .xpr_wdata_out(wdata));
    ctr_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .xpr_valid_in(valid), .xpr_write_in(wr),
        .xpr_addr_in(addr), .xpr_wdata_in(wdata), .auto_refresh_en_in(auto_en), .refresh_tick_in(tick),
        .normal_access_in(norm), .normal_btag_row_in(nb_row), .normal_ptag_row_in(np_row),
        .xpr_ack_out(ack), .xpr_rdata_out(rdata), .refresh_btag_out(rf_b), .refresh_ptag_banks_out(rf_p),
        .refresh_btag_row_out(rf_brow), .refresh_ptag_row_out(rf_prow), .tag_access_out(tacc),
        .tag_write_out(twr), .tag_sel_out(tsel), .tag_btag_row_out(tbr), .tag_btag_col_out(tbc),
        .tag_ptag_row_out(tpr), .tag_ptag_col_out(tpc));
    // Clock and a hang limit well above the roughly 310 cycles the tests need
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("Error timeout expected 3000 cycles seen more");
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        CPU.xfer(w, a, d, ok, rd);
        chk("ack", 32'h1, {31'h0, ok});
    endtask : rw
    task automatic t_reset();
        rw(1'h0, CTR_XPR_RFR, 32'h0);
        chk("ptr_rst", 32'h0, rd);
        rw(1'h0, CTR_XPR_IDX, 32'h0);
        chk("idx_rst", 32'h0, rd);
        rw(1'h0, 8'h76, 32'h0);
        chk("other_rd", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset
    task automatic t_ptr_write();
        rw(1'h1, CTR_XPR_RFR, 32'hFFFFABC0);
        chk("wr_refresh", 32'h7, {29'h0, rf_b, rf_p});
        chk("wr_rows", {19'h0, 8'hD5, 5'h1C}, {19'h0, rf_brow, rf_prow});
        rw(1'h0, CTR_XPR_RFR, 32'h0);
        chk("ptr_rd", 32'h0001ABC0, rd);
        $display("test pointer write done");
    endtask : t_ptr_write
    // Tick held high for 257 cycles, 256 of them checked: backup wraps once, primary wraps eight times
    task automatic t_auto();
        eb = 8'hD5;
        ep = 5'h1C;
        @(posedge mclk_in);
        auto_en <= 1'h1;
        tick <= 1'h1;
        for (int i = 0; i < 256; i++) begin
            @(posedge mclk_in);
            #1;
            chk("auto_rows", {16'h0, 1'h1, 2'h3, eb, ep}, {16'h0, rf_b, rf_p, rf_brow, rf_prow});
            eb++;
            ep++;
        end
        @(posedge mclk_in);
        tick <= 1'h0;
        auto_en <= 1'h0;
        eb++;
        ep++;
        rw(1'h0, CTR_XPR_RFR, 32'h0);
        chk("ptr_wrap", {15'h0, eb, ep, 4'h0}, rd);
        $display("test auto refresh done");
    endtask : t_auto
    task automatic t_index();
        logic [31:0] v;
        v = 32'h00015A50;
        rw(1'h1, CTR_XPR_IDX, 32'hFFFFFFFF);
        rw(1'h0, CTR_XPR_IDX, 32'h0);
        chk("idx_mask", 32'h0001FFF0, rd);
        rw(1'h1, CTR_XPR_IDX, v);
        @(posedge mclk_in);
        auto_en <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            rw(i == 0, CTR_XPR_BTAG + 8'(i), 32'h0);
            chk("sel_acc_wr", {28'h0, 2'(i), 1'h1, i == 0}, {28'h0, tsel, tacc, twr});
            chk("btag_idx", {21'h0, v[16:9], v[8:6]}, {21'h0, tbr, tbc});
            chk("ptag_idx", {25'h0, v[10:9], v[8:4]}, {25'h0, tpc, tpr});
        end
        @(posedge mclk_in);
        auto_en <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            rw(1'h0, CTR_XPR_BTAG + 8'(i), 32'h0);
            chk("ptr_idx", {14'h0, eb, ep, v[8:6], v[10:9]}, {14'h0, tbr, tpr, tbc, tpc});
            chk("acc_refresh", (i == 0) ? 32'h4 : 32'h3, {29'h0, rf_b, rf_p});
        end
        $display("test index done");
    endtask : t_index
    task automatic t_manual();
        @(posedge mclk_in);
        #1;
        chk("idle_refresh", 32'h0, {29'h0, rf_b, rf_p});
        @(posedge mclk_in);
        norm <= 1'h1;
        nb_row <= 8'h3C;
        np_row <= 5'h07;
        @(posedge mclk_in);
        norm <= 1'h0;
        #1;
        chk("norm_refresh", {16'h0, 3'h7, 8'h3C, 5'h07}, {16'h0, rf_b, rf_p, rf_brow, rf_prow});
        rw(1'h0, CTR_XPR_RFR, 32'h0);
        chk("ptr_hold", {15'h0, eb, ep, 4'h0}, rd);
        $display("test manual done");
    endtask : t_manual
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'h0;
        t_reset();
        t_ptr_write();
        t_auto();
        t_index();
        t_manual();
        tally_and_finish();
    end
endmodule : testbench
